/* hw/fault_pkg.sv */
package fault_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CAUSE = 8'h08;
  localparam logic [7:0] OFS_REASON = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_LIM_USR = 8'h14;
  localparam logic [7:0] OFS_LIM_SYS = 8'h18;
  localparam logic [7:0] OFS_LIM_SSM = 8'h1C;
  localparam logic [7:0] OFS_HV = 8'h20;
  localparam logic [7:0] OFS_SENS = 8'h24;
  // ----------------------------------------
  // Field layouts
  // ----------------------------------------
  // Asynchronous alarm inputs, index into sync vector
  localparam int NA = 7;
  localparam int A_VOLT = 0;
  localparam int A_FREQ = 1;
  localparam int A_TEMP = 2;
  localparam int A_LIGHT = 3;
  localparam int A_EELA = 4;
  localparam int A_EELB = 5;
  localparam int A_HV = 6;
  // Exception reason / interrupt status bits
  localparam int NR = 4;
  localparam int R_EELT = 0;
  localparam int R_FAULT = 1;
  localparam int R_ECC = 2;
  localparam int R_STACK = 3;
  // Reset cause bits
  localparam int NC = 6;
  localparam int C_POR = 0;
  localparam int C_VOLT = 1;
  localparam int C_FREQ = 2;
  localparam int C_TEMP = 3;
  localparam int C_LIGHT = 4;
  localparam int C_ROM = 5;
  // Control register fields
  localparam int K_INVECC = 0;
  localparam int K_LSEL_LO = 1;
  localparam int K_LSEL_HI = 2;
  localparam logic [1:0] LSEL_A = 2'h1;
  localparam logic [1:0] LSEL_B = 2'h2;
  // High-voltage status fields
  localparam int H_OK = 0;
  localparam int H_DONE = 1;
  // Fault detector inputs
  localparam int NF = 6;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [NC-1:0] CAUSE_RST = 6'h01;
  localparam logic [15:0] LIM_RST = 16'hFFFF;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] RST_LEN = 4'hF;
  typedef enum logic {
    ST_RUN,
    ST_RST
  } mon_state_t;
endpackage

/* hw/fault_response_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - voltage, frequency, temperature or light alarm forces a chip reset.
// - memory light detector or fault detector alarm raises an exception.
// - fault detectors: PC, SP, status word high, 3DES, AES, modular unit.
// - with inverse ECC enabled, any memory ECC error raises an exception.
// - power-on reset returns every register to its reset value; a forced chip reset keeps all but the reset cause.
// - cause of the latest reset is kept and software-readable.
// - each exception leaves a readable reason indication.
// - outside test mode all sensors are enabled automatically.
// - software writes can never turn sensors off.
// - reset or exception response per sensor is fixed in hardware.
// - three stack limit checkers: user, system, super system mode.
// - active stack pointer reaching its limit raises an exception.
// - each memory write samples high-voltage sensor into a register, no event.
// - software selects one of two memory light detectors or neither.
// - memory read path corrects single-bit errors per byte by itself.
// - ROM parity error forces a chip reset.
// - super system mode flag selects the super system stack checker.
module fault_response_monitor (
  input wire logic pclk, // System clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [fault_pkg::NA-1:0] alarm_async, // Sensor pins
  input wire logic rom_par_err, // ROM parity error
  input wire logic [fault_pkg::NF-1:0] fault_det, // Fault detectors
  input wire logic test_mode, // CPU in test mode
  input wire logic user_mode, // CPU in user mode
  input wire logic super_system_mode_flag, // Status word high flag
  input wire logic [15:0] sp_usr, // User stack pointer
  input wire logic [15:0] sp_sys, // System stack pointer
  input wire logic [15:0] sp_ssm, // Super system stack pointer
  input wire logic ee_rd_vld, // Memory read word valid
  input wire logic [11:0] ee_rd_code, // Memory read codeword
  input wire logic ee_wr_act, // Memory write sequence active
  output logic [7:0] ee_data, // Corrected read byte
  output logic ee_data_vld, // Corrected byte valid
  output logic chip_rst, // Forced chip reset
  output logic exc, // Exception pulse to CPU
  output logic irq, // Interrupt level
  output logic sens_en // Sensor enable
);
  import fault_pkg::*;

  typedef struct packed {
    logic [NA-1:0] sy1;
    logic [NA-1:0] sy2;
    logic [NR-1:0] status;
    logic [NR-1:0] mask;
    logic [NC-1:0] cause;
    logic [NR-1:0] reason;
    logic [2:0] ctrl;
    logic [15:0] lim_usr;
    logic [15:0] lim_sys;
    logic [15:0] lim_ssm;
    logic sp_hit;
    logic [1:0] hv;
    mon_state_t st;
    logic [3:0] rcnt;
    logic chip_rst;
    logic exc;
    logic irq;
    logic sens_en;
    logic [7:0] ee_data;
    logic ee_vld;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mon_t;

  mon_t q_r;
  mon_t q_nxt;

  // ----------------------------------------
  // Single-bit correction of one byte
  // ----------------------------------------
  function automatic logic [7:0] ecc_fix(input logic [11:0] cw, output logic err);
    logic [3:0] syn;
    logic [11:0] c;
    syn = 4'h0;
    for (int p = 1; p <= 12; p++) begin
      if (cw[p-1]) begin
        syn = syn ^ 4'(p);
      end
    end
    c = cw;
    for (int p = 1; p <= 12; p++) begin
      if (syn == 4'(p)) begin
        c[p-1] = ~c[p-1];
      end
    end
    err = (syn != 4'h0);
    return {c[11:8], c[6:4], c[2]};
  endfunction

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  logic [NC-1:0] rst_src;
  logic rst_al;
  logic [NR-1:0] exc_src;
  logic ecc_err;
  logic [7:0] fixed;
  logic [15:0] sp_act;
  logic [15:0] lim_act;
  logic sp_at;
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic [31:0] rdata;
  logic hit;

  // Alarm classification, hard-wired
  always_comb begin
    rst_src = '0;
    rst_src[C_VOLT] = q_r.sy2[A_VOLT] & q_r.sens_en;
    rst_src[C_FREQ] = q_r.sy2[A_FREQ] & q_r.sens_en;
    rst_src[C_TEMP] = q_r.sy2[A_TEMP] & q_r.sens_en;
    rst_src[C_LIGHT] = q_r.sy2[A_LIGHT] & q_r.sens_en;
    rst_src[C_ROM] = rom_par_err;
    rst_al = |rst_src;
    fixed = ecc_fix(ee_rd_code, ecc_err);
    // Stack checker select
    if (super_system_mode_flag) begin
      sp_act = sp_ssm;
      lim_act = q_r.lim_ssm;
    end else if (user_mode) begin
      sp_act = sp_usr;
      lim_act = q_r.lim_usr;
    end else begin
      sp_act = sp_sys;
      lim_act = q_r.lim_sys;
    end
    sp_at = (sp_act == lim_act);
    exc_src = '0;
    unique case (q_r.ctrl[K_LSEL_HI:K_LSEL_LO])
      LSEL_A: exc_src[R_EELT] = q_r.sy2[A_EELA];
      LSEL_B: exc_src[R_EELT] = q_r.sy2[A_EELB];
      default: exc_src[R_EELT] = 1'b0;
    endcase
    exc_src[R_FAULT] = |fault_det;
    exc_src[R_ECC] = ee_rd_vld & ecc_err & q_r.ctrl[K_INVECC];
    exc_src[R_STACK] = sp_at & ~q_r.sp_hit;
  end

  // APB decode and read mux
  always_comb begin
    setup = psel & ~penable & ~q_r.pready;
    wr_acc = psel & penable & q_r.pready & pwrite & ~q_r.pslverr;
    rd_acc = psel & penable & q_r.pready & ~pwrite & ~q_r.pslverr;
    rdata = '0;
    hit = 1'b1;
    unique case (paddr)
      OFS_STATUS: rdata[NR-1:0] = q_r.status;
      OFS_MASK: rdata[NR-1:0] = q_r.mask;
      OFS_CAUSE: rdata[NC-1:0] = q_r.cause;
      OFS_REASON: rdata[NR-1:0] = q_r.reason;
      OFS_CTRL: rdata[2:0] = q_r.ctrl;
      OFS_LIM_USR: rdata[15:0] = q_r.lim_usr;
      OFS_LIM_SYS: rdata[15:0] = q_r.lim_sys;
      OFS_LIM_SSM: rdata[15:0] = q_r.lim_ssm;
      OFS_HV: rdata[1:0] = q_r.hv;
      OFS_SENS: rdata[0] = q_r.sens_en;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.sy1 = alarm_async;
    q_nxt.sy2 = q_r.sy1;
    q_nxt.sens_en = ~test_mode;
    q_nxt.sp_hit = sp_at;
    q_nxt.exc = 1'b0;
    q_nxt.ee_vld = ee_rd_vld;
    if (ee_rd_vld) begin
      q_nxt.ee_data = fixed;
    end
    // High-voltage sample, no event raised
    if (ee_wr_act) begin
      q_nxt.hv[H_OK] = q_r.sy2[A_HV];
      q_nxt.hv[H_DONE] = 1'b1;
    end
    // Register writes
    if (wr_acc) begin
      unique case (paddr)
        OFS_MASK: q_nxt.mask = pwdata[NR-1:0];
        OFS_CTRL: q_nxt.ctrl = pwdata[2:0];
        OFS_LIM_USR: q_nxt.lim_usr = pwdata[15:0];
        OFS_LIM_SYS: q_nxt.lim_sys = pwdata[15:0];
        OFS_LIM_SSM: q_nxt.lim_ssm = pwdata[15:0];
        default: q_nxt.mask = q_r.mask;
      endcase
    end
    // Read clears interrupt status
    if (rd_acc && paddr == OFS_STATUS) begin
      q_nxt.status = '0;
    end
    // Forced reset sequencer
    unique case (q_r.st)
      ST_RUN: begin
        if (rst_al) begin
          q_nxt.st = ST_RST;
          q_nxt.chip_rst = 1'b1;
          q_nxt.rcnt = RST_LEN;
          q_nxt.cause = rst_src;
        end else if (|exc_src) begin
          q_nxt.exc = 1'b1;
          q_nxt.reason = exc_src;
          q_nxt.status = q_nxt.status | exc_src;
        end
      end
      ST_RST: begin
        if (q_r.rcnt == '0) begin
          q_nxt.st = ST_RUN;
          q_nxt.chip_rst = 1'b0;
        end else begin
          q_nxt.rcnt = q_r.rcnt - 4'h1;
        end
        if (rst_al) begin
          q_nxt.cause = rst_src;
        end
      end
    endcase
    q_nxt.irq = |(q_nxt.status & q_nxt.mask);
    // APB answer one cycle after setup
    q_nxt.pready = setup;
    q_nxt.pslverr = setup & ~hit;
    if (setup) begin
      q_nxt.prdata = hit ? rdata : '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
      q_r.cause <= CAUSE_RST;
      q_r.ctrl <= CTRL_RST;
      q_r.lim_usr <= LIM_RST;
      q_r.lim_sys <= LIM_RST;
      q_r.lim_ssm <= LIM_RST;
      q_r.sp_hit <= 1'b1;
      q_r.st <= ST_RUN;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign ee_data = q_r.ee_data;
  assign ee_data_vld = q_r.ee_vld;
  assign chip_rst = q_r.chip_rst;
  assign exc = q_r.exc;
  assign irq = q_r.irq;
  assign sens_en = q_r.sens_en;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RST_ALARM: assert property (
    (q_r.st == ST_RUN && rst_al) |=> chip_rst && $past(rst_src) == q_r.cause)
    else $error("sensor alarm did not force reset");
  AST_RST_HOLD: assert property (
    $rose(chip_rst) |-> chip_rst [*8])
    else $error("forced reset too short");
  AST_ROM_RST: assert property (
    (q_r.st == ST_RUN && rom_par_err) |=> chip_rst && q_r.cause[C_ROM])
    else $error("rom parity did not reset");
  AST_FAULT_EXC: assert property (
    (q_r.st == ST_RUN && !rst_al && |fault_det) |=> exc && q_r.reason[R_FAULT])
    else $error("fault detector gave no exception");
  AST_RST_PRIO: assert property (
    rst_al |=> !exc)
    else $error("exception raised beside reset");
  AST_ECC_EXC: assert property (
    (q_r.st == ST_RUN && !rst_al && ee_rd_vld && ecc_err && q_r.ctrl[K_INVECC])
    |=> exc ##0 q_r.reason[R_ECC])
    else $error("ecc error gave no exception");
  AST_SENS_ON: assert property (
    (presetn && !test_mode) |=> sens_en)
    else $error("sensors off outside test mode");
  AST_HV_SAMPLE: assert property (
    ee_wr_act |=> q_r.hv[H_DONE] && q_r.hv[H_OK] == $past(q_r.sy2[A_HV]))
    else $error("high voltage not sampled");
  AST_STACK_EXC: assert property (
    (q_r.st == ST_RUN && !rst_al && sp_at && !q_r.sp_hit) |=> exc && q_r.reason[R_STACK])
    else $error("stack limit gave no exception");
  AST_IRQ: assert property (
    (exc && |(q_r.reason & q_r.mask)) |-> irq ##1 (irq || $past(rd_acc)))
    else $error("masked-in exception gave no interrupt");
endmodule
`default_nettype wire

/* test/sensor_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_cpu_model (
  input wire logic pclk, // System clock
  output logic [fault_pkg::NA-1:0] alarm_async, // Sensor pins
  output logic rom_par_err, // ROM parity error
  output logic [fault_pkg::NF-1:0] fault_det, // Fault detectors
  output logic test_mode, // CPU test mode
  output logic user_mode, // CPU user mode
  output logic super_system_mode_flag, // Status word high flag
  output logic [15:0] sp_usr, // User stack pointer
  output logic [15:0] sp_sys, // System stack pointer
  output logic [15:0] sp_ssm, // Super system stack pointer
  output logic ee_rd_vld, // Memory read valid
  output logic [11:0] ee_rd_code, // Memory codeword
  output logic ee_wr_act // Memory write active
);
  import fault_pkg::*;
  // ----------------------------------------
  // Idle state: supply fine, system mode
  // ----------------------------------------
  initial begin
    alarm_async = 7'h40;
    {rom_par_err, fault_det, test_mode, user_mode, super_system_mode_flag} = '0;
    {sp_usr, sp_sys, sp_ssm, ee_rd_vld, ee_rd_code, ee_wr_act} = '0;
  end
  // Sensor pins at v for n cycles, then idle
  task automatic pin(input logic [6:0] v, input int n);
    @(posedge pclk) alarm_async <= v;
    repeat (n) @(posedge pclk);
    alarm_async <= 7'h40;
  endtask
  // One-cycle detector strike
  task automatic strike(input logic [5:0] f, input logic r);
    @(posedge pclk) fault_det <= f;
    rom_par_err <= r;
    @(posedge pclk) fault_det <= '0;
    rom_par_err <= 1'b0;
  endtask
  // Memory read; code line scrambled once released
  task automatic code_rd(input logic [11:0] c);
    @(posedge pclk) ee_rd_vld <= 1'b1;
    ee_rd_code <= c;
    @(posedge pclk) ee_rd_vld <= 1'b0;
    ee_rd_code <= ~c;
  endtask
  // Memory write sequence with high-voltage level hv
  task automatic write_seq(input logic hv);
    @(posedge pclk) ee_wr_act <= 1'b1;
    alarm_async[A_HV] <= hv;
    repeat (6) @(posedge pclk);
    ee_wr_act <= 1'b0;
    alarm_async[A_HV] <= 1'b1;
  endtask
  // CPU test mode level
  task automatic tmode(input logic t);
    @(posedge pclk) test_mode <= t;
  endtask
  // Mode 0 user, 1 system, 2 super system; pointers {ssm,sys,usr}
  task automatic cpu(input int md, input logic [47:0] sps);
    @(posedge pclk) user_mode <= (md == 0);
    super_system_mode_flag <= (md == 2);
    {sp_ssm, sp_sys, sp_usr} <= sps;
  endtask
endmodule
`default_nettype wire

/* test/fault_response_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_response_monitor_tb;
  import fault_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, rst_d;
  logic [7:0] paddr, ee_data, got;
  logic [31:0] pwdata, prdata, rdat;
  logic [NA-1:0] alarm_async;
  logic [NF-1:0] fault_det;
  logic rom_par_err, test_mode, user_mode, super_system_mode_flag;
  logic [15:0] sp_usr, sp_sys, sp_ssm;
  logic ee_rd_vld, ee_wr_act, ee_data_vld, chip_rst, exc, irq, sens_en;
  logic [11:0] ee_rd_code;
  int err_count = 0, tests_run = 0, exc_n = 0, rst_n = 0, cyc = 0, e0, r0;

  fault_response_monitor uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_async(alarm_async),
    .rom_par_err(rom_par_err), .fault_det(fault_det), .test_mode(test_mode),
    .user_mode(user_mode), .super_system_mode_flag(super_system_mode_flag),
    .sp_usr(sp_usr), .sp_sys(sp_sys), .sp_ssm(sp_ssm), .ee_rd_vld(ee_rd_vld),
    .ee_rd_code(ee_rd_code), .ee_wr_act(ee_wr_act), .ee_data(ee_data),
    .ee_data_vld(ee_data_vld), .chip_rst(chip_rst), .exc(exc), .irq(irq), .sens_en(sens_en));
  sensor_cpu_model far (.pclk(pclk), .alarm_async(alarm_async), .rom_par_err(rom_par_err),
    .fault_det(fault_det), .test_mode(test_mode), .user_mode(user_mode),
    .super_system_mode_flag(super_system_mode_flag), .sp_usr(sp_usr), .sp_sys(sp_sys),
    .sp_ssm(sp_ssm), .ee_rd_vld(ee_rd_vld), .ee_rd_code(ee_rd_code), .ee_wr_act(ee_wr_act));

  // ----------------------------------------
  // Clock, event counters, timeout
  // ----------------------------------------
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (exc === 1'b1) exc_n <= exc_n + 1;
    if (chip_rst === 1'b1 && !rst_d) rst_n <= rst_n + 1;
    rst_d <= (chip_rst === 1'b1);
    if (ee_data_vld === 1'b1) got <= ee_data;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done;
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB transfer; read data and error taken at the ready edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Hamming codeword, even parity at positions 1,2,4,8
  function automatic logic [11:0] enc(input logic [7:0] d);
    logic [12:1] c;
    c = '0;
    {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = d;
    for (int p = 1; p < 16; p = p * 2)
      for (int k = 3; k <= 12; k++)
        if ((k & p) != 0 && k != p) c[p] ^= c[k];
    return c;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, rst_d} = '0;
    tick(4);
    presetn <= 1'b1;
    tick(2);
    chk("sens_en", sens_en, 1);
    acc(0, OFS_CAUSE, 0); chk("cause", rdat, CAUSE_RST);
    acc(0, OFS_LIM_USR, 0); chk("lim", rdat, LIM_RST);
    acc(0, 8'h3C, 0); chk("slverr", rerr, 1);
    chk("unmapped", rdat, 0);
    acc(1, OFS_SENS, 0); acc(0, OFS_SENS, 0); chk("sens", rdat, 1);
    acc(1, OFS_MASK, 32'h0000000F);
    for (int i = 0; i < NF; i++) begin
      e0 = exc_n; far.strike(6'h01 << i, 0); tick(4);
      chk("fault exc", exc_n - e0, 1);
      chk("irq", irq, 1);
      acc(0, OFS_REASON, 0); chk("reason", rdat, 1 << R_FAULT);
      acc(0, OFS_STATUS, 0); chk("status", rdat, 1 << R_FAULT);
      tick(2); chk("irq clr", irq, 0);
    end
    acc(1, OFS_MASK, 0); far.strike(6'h02, 0); tick(4); chk("masked", irq, 0);
    // Memory light detector selection: sel 0/3 off, 1 A, 2 B
    for (int i = 0; i < 8; i++) begin
      acc(1, OFS_CTRL, (i >> 1) << K_LSEL_LO); e0 = exc_n;
      far.pin(((i & 1) != 0) ? 7'h60 : 7'h50, 1); tick(6);
      chk("mem light", exc_n != e0, (i >> 1) == (1 + (i & 1)));
    end
    for (int en = 0; en < 2; en++) begin
      acc(1, OFS_CTRL, en); e0 = exc_n;
      far.code_rd(enc(8'hA5) ^ (12'h040 << en)); tick(4);
      chk("ecc data", got, 8'hA5);
      chk("ecc exc", exc_n != e0, en);
    end
    acc(1, OFS_LIM_USR, 32'h110); acc(1, OFS_LIM_SYS, 32'h120); acc(1, OFS_LIM_SSM, 32'h130);
    for (int i = 0; i < 9; i++) begin
      far.cpu(i / 3, 48'h0); tick(3); e0 = exc_n;
      far.cpu(i / 3, (48'h110 + ((i % 3) << 4)) << (16 * (i % 3))); tick(4);
      chk("stack", exc_n != e0, (i / 3) == (i % 3));
    end
    far.cpu(1, 48'h0);
    e0 = exc_n; r0 = rst_n;
    far.write_seq(1); tick(2); acc(0, OFS_HV, 0); chk("hv ok", rdat, 3);
    far.write_seq(0); tick(2); acc(0, OFS_HV, 0); chk("hv low", rdat, 2);
    chk("hv quiet", (exc_n != e0) || (rst_n != r0), 0);
    far.tmode(1); tick(2); chk("test mode", sens_en, 0);
    r0 = rst_n; far.pin(7'h41, 1); tick(6); chk("test quiet", rst_n - r0, 0);
    far.tmode(0); tick(2); chk("sens back", sens_en, 1);
    for (int i = 0; i < 4; i++) begin
      r0 = rst_n; far.pin(7'h40 | (7'h01 << i), 1); tick(25);
      chk("sensor rst", rst_n - r0, 1);
      acc(0, OFS_CAUSE, 0); chk("cause", rdat, 2 << i);
    end
    r0 = rst_n; e0 = exc_n; far.strike(6'h01, 1); tick(25);
    chk("rom rst", rst_n - r0, 1);
    chk("prio", exc_n - e0, 0);
    acc(0, OFS_CAUSE, 0); chk("rom cause", rdat, 1 << C_ROM);
    acc(1, OFS_CTRL, 5);
    presetn <= 1'b0; tick(2); presetn <= 1'b1; tick(2);
    acc(0, OFS_CAUSE, 0); chk("cause again", rdat, CAUSE_RST);
    acc(0, OFS_CTRL, 0); chk("ctrl", rdat, CTRL_RST);
    test_done();
  end
endmodule
`default_nettype wire
